// ### erf_block.v
`include "erf_consts.vh"

// How it works
// - Every read and write happens on an edge.
// - Read and write sides each run independently.
// - Dual-port shapes run 4kx1 through 512x9.
// - Two-port shapes 512x9, 256x18, fixed directions.
// - Synchronous write, pipelined or plain read.
// - FIFO controller makes addresses and four flags.
// - RAM mode: user addresses, FIFO controller ignored.
// - FIFO mode: pointers muxed into the array.
// - Write and read shapes chosen independently.
// - Narrow ports leave the ninth bit unused.
// - Nine-bit words read as two nibbles.
// - Ninth bit undefined after narrow writes.
// - Narrow words packed little-endian into wider.
// - Pipeline select adds one cycle of latency.
// - Deselected port holds its outputs once a pending pipelined read lands.
// - Reset zeroes data outputs, keeps memory contents.
module erf_block (
	input  wire        CLK,
	input  wire        RST_N,
	input  wire [1:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	input  wire        PORT_A_SELECT_N,
	input  wire        PORT_A_WRITE_N,
	input  wire [11:0] PORT_A_ADDR,
	input  wire [17:0] PORT_A_WDATA,
	output reg  [17:0] PORT_A_RDATA,
	input  wire        PORT_B_SELECT_N,
	input  wire        PORT_B_WRITE_N,
	input  wire [11:0] PORT_B_ADDR,
	input  wire [17:0] PORT_B_WDATA,
	output reg  [17:0] PORT_B_RDATA,
	output reg         FULL_FLAG,
	output reg         EMPTY_FLAG,
	output reg         ALMOST_FULL_FLAG,
	output reg         ALMOST_EMPTY_FLAG
);

	// ****************************************************************
	// Helper functions for shape handling.
	// ****************************************************************

	// Row of the 256x18 array that holds the addressed word.
	function [7:0] row_of;
		input [2:0]  w;
		input [11:0] a;
		begin
			case (w)
				`ERF_W1:  row_of = a[11:4];
				`ERF_W2:  row_of = a[10:3];
				`ERF_W4:  row_of = a[9:2];
				`ERF_W9:  row_of = a[8:1];
				default:  row_of = a[7:0];
			endcase
		end
	endfunction

	// Bit offset inside the row; lower addresses sit in lower bits.
	function [4:0] off_of;
		input [2:0]  w;
		input [11:0] a;
		reg   [4:0]  half;
		begin
			half = a[0] ? `ERF_HALF_OFS : `ERF_ZERO_OFS;
			case (w)
				`ERF_W1:  off_of = (a[3] ? `ERF_HALF_OFS : `ERF_ZERO_OFS) + {2'h0, a[2:0]};
				`ERF_W2:  off_of = (a[2] ? `ERF_HALF_OFS : `ERF_ZERO_OFS) + {2'h0, a[1:0], 1'b0};
				`ERF_W4:  off_of = (a[1] ? `ERF_HALF_OFS : `ERF_ZERO_OFS)
					+ (a[0] ? `ERF_NIB_OFS : `ERF_ZERO_OFS);
				`ERF_W9:  off_of = half;
				default:  off_of = `ERF_ZERO_OFS;
			endcase
		end
	endfunction

	// Data lanes used by a shape; narrow shapes never touch the ninth bit.
	function [17:0] mask_of;
		input [2:0] w;
		begin
			case (w)
				`ERF_W1:  mask_of = `ERF_MASK_W1;
				`ERF_W2:  mask_of = `ERF_MASK_W2;
				`ERF_W4:  mask_of = `ERF_MASK_W4;
				`ERF_W9:  mask_of = `ERF_MASK_W9;
				default:  mask_of = `ERF_MASK_W18;
			endcase
		end
	endfunction

	// Shape actually used: dual-port tops out at x9, two-port is x9 or x18.
	// Out-of-range codes are clamped rather than refused, so a bad width
	// select still yields a defined layout instead of a hole in the array.
	function [2:0] eff_of;
		input [1:0] m;
		input [2:0] w;
		begin
			if (m == `ERF_MODE_DP) begin
				eff_of = (w > `ERF_W9) ? `ERF_W9 : w;
			end else if (m == `ERF_MODE_TP) begin
				eff_of = (w < `ERF_W9) ? `ERF_W9 : ((w > `ERF_W18) ? `ERF_W18 : w);
			end else begin
				eff_of = (w > `ERF_W18) ? `ERF_W18 : w;
			end
		end
	endfunction

	// ****************************************************************
	// Registers and internal signals.
	// ****************************************************************
	reg  [10:0] ctrl;            // Mode, width selects, pipeline selects.
	reg  [12:0] almost_full_flag_level;     // Almost-full threshold in bit units.
	reg  [12:0] almost_empty_flag_level;    // Almost-empty threshold in bit units.
	reg  [12:0] wr_ptr;          // FIFO write pointer, one wrap bit on top.
	reg  [12:0] rd_ptr;          // FIFO read pointer, one wrap bit on top.
	reg  [17:0] a_stage;         // First stage of the pipelined port A read.
	reg  [17:0] b_stage;         // First stage of the pipelined port B read.
	reg         a_stage_vld;     // Port A stage holds a fresh word.
	reg         b_stage_vld;     // Port B stage holds a fresh word.
	reg  [12:0] next_wr_ptr;     // Write pointer after this edge.
	reg  [12:0] next_rd_ptr;     // Read pointer after this edge.
	reg  [12:0] next_level;      // Fill level after this edge.
	reg  [31:0] rd_mux;          // Register read value.

	// Decoded mode and effective shapes; a step is one word of that shape
	// counted in bits, which is the unit of both FIFO pointers.
	wire [1:0]  mode      = ctrl[`ERF_CTRL_MODE];
	wire        fifo_mode = (mode == `ERF_MODE_FIFO);
	wire [2:0]  wa        = eff_of(mode, ctrl[`ERF_CTRL_WSEL]);
	wire [2:0]  wb        = eff_of(mode, ctrl[`ERF_CTRL_RSEL]);
	wire [12:0] step_a    = `ERF_ONE_UNIT << wa;
	wire [12:0] step_b    = `ERF_ONE_UNIT << wb;
	// The wrap bit on top keeps a full queue distinct from an empty one.
	wire [12:0] level     = wr_ptr - rd_ptr;

	// ****************************************************************
	// Port request decode.
	// ****************************************************************

	// Port A writes on low write-enable; in two-port mode it only writes.
	// A refused push or pop never reaches the array or the pointers.
	wire a_sel = ~PORT_A_SELECT_N;
	wire b_sel = ~PORT_B_SELECT_N;
	wire a_wr  = a_sel & ~PORT_A_WRITE_N & ~(fifo_mode & FULL_FLAG);
	wire a_rd  = a_sel & PORT_A_WRITE_N & (mode == `ERF_MODE_DP);
	wire b_wr  = b_sel & ~PORT_B_WRITE_N & (mode == `ERF_MODE_DP);
	wire b_rd  = b_sel & PORT_B_WRITE_N & ~(fifo_mode & EMPTY_FLAG);

	// In FIFO mode the pointers replace the user addresses.
	// Both sides share one clock, so the pointers cross no domain and need
	// no gray coding; separate clocks would need it.
	wire [11:0] a_addr = fifo_mode ? (wr_ptr[11:0] >> wa) : PORT_A_ADDR;
	wire [11:0] b_addr = fifo_mode ? (rd_ptr[11:0] >> wb) : PORT_B_ADDR;
	wire [7:0]  a_row  = row_of(wa, a_addr);
	wire [7:0]  b_row  = row_of(wb, b_addr);
	wire [4:0]  a_off  = off_of(wa, a_addr);
	wire [4:0]  b_off  = off_of(wb, b_addr);
	wire [17:0] a_mask = mask_of(wa) << a_off;
	wire [17:0] b_mask = mask_of(wb) << b_off;
	wire [17:0] a_q;
	wire [17:0] b_q;

	// Read words are shifted down and trimmed; unused upper bits read zero.
	wire [17:0] a_word = (a_q >> a_off) & mask_of(wa);
	wire [17:0] b_word = (b_q >> b_off) & mask_of(wb);

	// ****************************************************************
	// Storage array.
	// ****************************************************************
	// Write data is moved into its lane here, so the array only ever
	// sees whole rows with a lane mask beside them.
	erf_mem u_mem (
		.clk    (CLK),
		.a_we   (a_wr),
		.a_row  (a_row),
		.a_data ((PORT_A_WDATA & mask_of(wa)) << a_off),
		.a_mask (a_mask),
		.a_q    (a_q),
		.b_we   (b_wr),
		.b_row  (b_row),
		.b_data ((PORT_B_WDATA & mask_of(wb)) << b_off),
		.b_mask (b_mask),
		.b_q    (b_q)
	);

	// ****************************************************************
	// Read data paths.
	// ****************************************************************

	// Port A output: direct on the read edge, or one edge later when
	// pipelined. While deselected, only a pending pipelined read still lands.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			// Reset clears the visible word and the stage, never the array.
			PORT_A_RDATA <= 18'h00000;
			a_stage      <= 18'h00000;
			a_stage_vld  <= 1'b0;
		end else begin
			a_stage_vld <= a_rd;
			if (a_rd) begin
				a_stage <= a_word;
			end
			if (ctrl[`ERF_CTRL_PORT_A_PIPELINE_SEL]) begin
				if (a_stage_vld) begin
					PORT_A_RDATA <= a_stage;
				end
			end else if (a_rd) begin
				PORT_A_RDATA <= a_word;
			end
		end
	end

	// Port B output, same scheme; in FIFO mode a pop refused while empty returns no word.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			// Reset clears the visible word and the stage, never the array.
			PORT_B_RDATA <= 18'h00000;
			b_stage      <= 18'h00000;
			b_stage_vld  <= 1'b0;
		end else begin
			b_stage_vld <= b_rd;
			if (b_rd) begin
				b_stage <= b_word;
			end
			if (ctrl[`ERF_CTRL_PIPEB]) begin
				if (b_stage_vld) begin
					PORT_B_RDATA <= b_stage;
				end
			end else if (b_rd) begin
				PORT_B_RDATA <= b_word;
			end
		end
	end

	// ****************************************************************
	// FIFO controller.
	// ****************************************************************

	// Pointers advance in bit units so mixed shapes share one count.
	// With one clock both sides step here; the flags below are still
	// computed from the side that owns them.
	always @* begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		// A flush wins over any push or pop in the same cycle.
		if (ctrl[`ERF_CTRL_FLUSH]) begin
			next_wr_ptr = 13'h0000;
			next_rd_ptr = 13'h0000;
		end else if (fifo_mode) begin
			if (a_wr) begin
				next_wr_ptr = wr_ptr + step_a;
			end
			if (b_rd) begin
				next_rd_ptr = rd_ptr + step_b;
			end
		end
		next_level = next_wr_ptr - next_rd_ptr;
	end

	// Flags are registered from the next pointers, so they match them.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			// After reset the queue is empty, so both low-side flags start high.
			wr_ptr            <= 13'h0000;
			rd_ptr            <= 13'h0000;
			FULL_FLAG         <= 1'b0;
			ALMOST_FULL_FLAG  <= 1'b0;
			EMPTY_FLAG        <= 1'b1;
			ALMOST_EMPTY_FLAG <= 1'b1;
		end else begin
			wr_ptr            <= next_wr_ptr;
			rd_ptr            <= next_rd_ptr;
			// Full means the next push of the write shape would not fit.
			FULL_FLAG         <= (next_level + step_a) > `ERF_CAPACITY;
			ALMOST_FULL_FLAG  <= next_level >= almost_full_flag_level;
			// Empty means less than one word of the read shape remains.
			EMPTY_FLAG        <= next_level < step_b;
			ALMOST_EMPTY_FLAG <= next_level <= almost_empty_flag_level;
		end
	end

	// ****************************************************************
	// Avalon-MM register slave.
	// ****************************************************************

	// Read value of the addressed register; unmapped indices read zero.
	always @* begin
		rd_mux = 32'h00000000;
		case (AVS_ADDRESS)
			`ERF_REG_CTRL:   rd_mux[`ERF_CTRL_BITS] = ctrl;
			`ERF_REG_ALMOST_FULL_FLAG:  rd_mux[`ERF_PTR_BITS]  = almost_full_flag_level;
			`ERF_REG_ALMOST_EMPTY_FLAG: rd_mux[`ERF_PTR_BITS]  = almost_empty_flag_level;
			`ERF_REG_STATUS: begin
				rd_mux[`ERF_STAT_FLAGS] = {ALMOST_EMPTY_FLAG, ALMOST_FULL_FLAG,
					EMPTY_FLAG, FULL_FLAG};
				rd_mux[`ERF_STAT_LEVEL] = level;
			end
			default:         rd_mux = 32'h00000000;
		endcase
	end

	// Waitrequest rests high and drops for exactly one cycle per access.
	// The extra cycle keeps read data and the answer from a flip-flop.
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h00000000;
			// The slave comes out of reset stalled, waiting for a request.
			ctrl            <= `ERF_CTRL_RESET;
			almost_full_flag_level     <= `ERF_ALMOST_FULL_FLAG_RESET;
			almost_empty_flag_level    <= `ERF_ALMOST_EMPTY_FLAG_RESET;
		end else begin
			// The flush bit only lives for one cycle.
			ctrl[`ERF_CTRL_FLUSH] <= 1'b0;
			if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST) begin
				AVS_WAITREQUEST <= 1'b0;
				AVS_READDATA    <= AVS_READ ? rd_mux : 32'h00000000;
			end else begin
				AVS_WAITREQUEST <= 1'b1;
			end
			// A write lands on the edge where waitrequest is seen low.
			if (AVS_WRITE & ~AVS_WAITREQUEST) begin
				case (AVS_ADDRESS)
					`ERF_REG_CTRL:   ctrl         <= AVS_WRITEDATA[`ERF_CTRL_BITS];
					`ERF_REG_ALMOST_FULL_FLAG:  almost_full_flag_level  <= AVS_WRITEDATA[`ERF_PTR_BITS];
					`ERF_REG_ALMOST_EMPTY_FLAG: almost_empty_flag_level <= AVS_WRITEDATA[`ERF_PTR_BITS];
					// The status word is read-only, so a write to it is dropped.
					default:         ctrl[`ERF_CTRL_FLUSH] <= 1'b0;
				endcase
			end
		end
	end

endmodule // erf_block

// ### erf_consts.vh
`ifndef ERF_CONSTS_VH
`define ERF_CONSTS_VH

// ****************************************************************
// Operating modes of the memory block.
// ****************************************************************
`define ERF_MODE_DP       2'h0
`define ERF_MODE_TP       2'h1
`define ERF_MODE_FIFO     2'h2

// ****************************************************************
// Depth-by-width shape codes; the code is also the address shift.
// ****************************************************************
`define ERF_W1            3'h0
`define ERF_W2            3'h1
`define ERF_W4            3'h2
`define ERF_W9            3'h3
`define ERF_W18           3'h4

// Lane masks for each shape, and the bit position of the upper half-row.
`define ERF_MASK_W1       18'h00001
`define ERF_MASK_W2       18'h00003
`define ERF_MASK_W4       18'h0000f
`define ERF_MASK_W9       18'h001ff
`define ERF_MASK_W18      18'h3ffff
`define ERF_HALF_OFS      5'h09
`define ERF_NIB_OFS       5'h04
`define ERF_ZERO_OFS      5'h00

// ****************************************************************
// Register word indices on the Avalon-MM slave.
// ****************************************************************
`define ERF_REG_CTRL      2'h0
`define ERF_REG_ALMOST_FULL_FLAG     2'h1
`define ERF_REG_ALMOST_EMPTY_FLAG    2'h2
`define ERF_REG_STATUS    2'h3

// Control register fields and reset value.
`define ERF_CTRL_MODE     1:0
`define ERF_CTRL_WSEL     4:2
`define ERF_CTRL_RSEL     7:5
`define ERF_CTRL_PORT_A_PIPELINE_SEL    8
`define ERF_CTRL_PIPEB    9
`define ERF_CTRL_FLUSH    10
`define ERF_CTRL_BITS     10:0
`define ERF_CTRL_RESET    11'h06c

// Threshold registers, in units of one bit of capacity (4096 total).
`define ERF_PTR_BITS      12:0
`define ERF_ALMOST_FULL_FLAG_RESET   13'h0e00
`define ERF_ALMOST_EMPTY_FLAG_RESET  13'h0200
`define ERF_CAPACITY      13'h1000
`define ERF_ONE_UNIT      13'h0001

// Status register fields.
`define ERF_STAT_FLAGS    3:0
`define ERF_STAT_LEVEL    16:4

`endif

// ### erf_mem.v
`include "erf_consts.vh"

// ****************************************************************
// Storage array of 256 rows by 18 bits with two masked write ports
// and two read ports. Rows are read without a clock; the caller
// registers the result, so every access still completes on an edge.
// ****************************************************************
module erf_mem (
	input  wire        clk,
	input  wire        a_we,
	input  wire [7:0]  a_row,
	input  wire [17:0] a_data,
	input  wire [17:0] a_mask,
	output wire [17:0] a_q,
	input  wire        b_we,
	input  wire [7:0]  b_row,
	input  wire [17:0] b_data,
	input  wire [17:0] b_mask,
	output wire [17:0] b_q
);

	// Contents are never reset, so a reset leaves stored data intact.
	reg [17:0] mem [0:255];

	assign a_q = mem[a_row];
	assign b_q = mem[b_row];

	// Masked writes; on a collision in one row port B lands last.
	always @(posedge clk) begin
		if (a_we) begin
			mem[a_row] <= (mem[a_row] & ~a_mask) | (a_data & a_mask);
		end
		if (b_we) begin
			mem[b_row] <= (mem[b_row] & ~b_mask) | (b_data & b_mask);
		end
	end

endmodule // erf_mem

// ### erf_block_sva.sv
// ****************************************************************
// Port-level checks for the memory block and its register slave.
// ****************************************************************
module erf_block_sva (
	input wire        CLK,
	input wire        RST_N,
	input wire        AVS_READ,
	input wire        AVS_WRITE,
	input wire [31:0] AVS_READDATA,
	input wire        AVS_WAITREQUEST,
	input wire        PORT_A_SELECT_N,
	input wire        PORT_A_WRITE_N,
	input wire [17:0] PORT_A_RDATA,
	input wire        PORT_B_SELECT_N,
	input wire        PORT_B_WRITE_N,
	input wire [17:0] PORT_B_RDATA,
	input wire        FULL_FLAG,
	input wire        EMPTY_FLAG,
	input wire        ALMOST_EMPTY_FLAG
);
	timeunit 1ns;
	timeprecision 1ns;
	// A push on port A and a pop on port B, as seen at the pins.
	wire push_seen = !PORT_A_SELECT_N && !PORT_A_WRITE_N;
	wire pop_seen  = !PORT_B_SELECT_N && PORT_B_WRITE_N;
	// One clock domain, so every check shares this clock; all but p_reset also share this reset.
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// A bus request that finds the slave idle.
	sequence s_req;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	// Two edges with no read taken on a port.
	sequence s_quiet_a;
		(PORT_A_SELECT_N || !PORT_A_WRITE_N)[*2];
	endsequence
	sequence s_quiet_b;
		(PORT_B_SELECT_N || !PORT_B_WRITE_N)[*2];
	endsequence
	// Reset seen at two edges, so the async clear has surely landed.
	sequence s_held;
		!RST_N[*2];
	endsequence
	property p_answer;
		s_req |=> !AVS_WAITREQUEST;
	endproperty
	a_answer: assert property (p_answer) else $error("bus access not answered");
	property p_single;
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST;
	endproperty
	a_single: assert property (p_single) else $error("wait low too long");
	property p_reset;
		@(posedge CLK) disable iff (1'b0)
		s_held |-> (PORT_A_RDATA | PORT_B_RDATA) == 18'h0 && AVS_READDATA == 32'h0
			&& EMPTY_FLAG && !FULL_FLAG;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared in reset");
	property p_hold_a;
		s_quiet_a |=> $stable(PORT_A_RDATA);
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("port A data moved");
	property p_hold_b;
		s_quiet_b |=> $stable(PORT_B_RDATA);
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("port B data moved");
	property p_almost_empty_flag;
		EMPTY_FLAG |-> ALMOST_EMPTY_FLAG;
	endproperty
	a_almost_empty_flag: assert property (p_almost_empty_flag) else $error("empty without almost empty");
	// A register write lands one edge after it is sampled and reaches the
	// registered flags one edge later still, so it is looked for two back.
	property p_drain;
		$rose(EMPTY_FLAG) |-> $past(pop_seen) || $past(AVS_WRITE, 2);
	endproperty
	a_drain: assert property (p_drain) else $error("empty rose without a pop");
	property p_fill;
		$fell(EMPTY_FLAG) |-> $past(push_seen) || $past(AVS_WRITE, 2);
	endproperty
	a_fill: assert property (p_fill) else $error("empty fell without a push");
	property p_full;
		$rose(FULL_FLAG) |-> $past(push_seen) || $past(AVS_WRITE, 2);
	endproperty
	a_full: assert property (p_full) else $error("full rose without a push");
endmodule // erf_block_sva

bind erf_block erf_block_sva i_erf_block_sva (.CLK, .RST_N, .AVS_READ, .AVS_WRITE,
	.AVS_READDATA, .AVS_WAITREQUEST, .PORT_A_SELECT_N, .PORT_A_WRITE_N, .PORT_A_RDATA,
	.PORT_B_SELECT_N, .PORT_B_WRITE_N, .PORT_B_RDATA, .FULL_FLAG, .EMPTY_FLAG,
	.ALMOST_EMPTY_FLAG);

// ### erf_fabric.sv
// ****************************************************************
// Fabric logic that drives both memory ports, one access per edge.
// ****************************************************************
module erf_fabric (
	input  wire        clk,
	output reg         a_sel_n,
	output reg         a_wr_n,
	output reg  [11:0] a_addr,
	output reg  [17:0] a_wdata,
	output reg         b_sel_n,
	output reg         b_wr_n,
	output reg  [11:0] b_addr,
	output reg  [17:0] b_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Both ports start deselected.
	initial begin
		{a_sel_n, b_sel_n} = 2'b11;
		{a_wr_n, b_wr_n, a_addr, b_addr, a_wdata, b_wdata} = 62'h0;
	end
	// Present one access; the design takes it at the next edge.
	// The other port is deselected so it never repeats an old access.
	task automatic op(input logic pb, input logic wr, input logic [11:0] ad,
		input logic [17:0] d);
		@(posedge clk);
		a_sel_n <= pb;
		b_sel_n <= !pb;
		{a_wr_n, b_wr_n} <= {2{!wr}};
		{a_addr, b_addr} <= {2{ad}};
		{a_wdata, b_wdata} <= {2{d}};
	endtask
	// Release both ports; address and data lines flip so stale values never look valid.
	task automatic idle();
		@(posedge clk);
		{a_sel_n, b_sel_n} <= 2'b11;
		{a_addr, b_addr, a_wdata, b_wdata} <= ~{a_addr, b_addr, a_wdata, b_wdata};
	endtask
endmodule // erf_fabric

// ### test_erf_block.sv
module test_erf_block;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
	logic [1:0]  AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
	logic        PORT_A_SELECT_N, PORT_A_WRITE_N, PORT_B_SELECT_N, PORT_B_WRITE_N;
	logic [11:0] PORT_A_ADDR, PORT_B_ADDR;
	logic [17:0] PORT_A_WDATA, PORT_B_WDATA, PORT_A_RDATA, PORT_B_RDATA;
	logic        FULL_FLAG, EMPTY_FLAG, ALMOST_FULL_FLAG, ALMOST_EMPTY_FLAG;
	int          failures, comparisons;
	erf_block i_erf_block (.CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
		.AVS_READDATA, .AVS_WAITREQUEST, .PORT_A_SELECT_N, .PORT_A_WRITE_N, .PORT_A_ADDR,
		.PORT_A_WDATA, .PORT_A_RDATA, .PORT_B_SELECT_N, .PORT_B_WRITE_N, .PORT_B_ADDR,
		.PORT_B_WDATA, .PORT_B_RDATA, .FULL_FLAG, .EMPTY_FLAG, .ALMOST_FULL_FLAG,
		.ALMOST_EMPTY_FLAG);
	erf_fabric u_fab (.clk(CLK), .a_sel_n(PORT_A_SELECT_N), .a_wr_n(PORT_A_WRITE_N),
		.a_addr(PORT_A_ADDR), .a_wdata(PORT_A_WDATA), .b_sel_n(PORT_B_SELECT_N),
		.b_wr_n(PORT_B_WRITE_N), .b_addr(PORT_B_ADDR), .b_wdata(PORT_B_WDATA));
	// ****************************************************************
	// Clock, shared helpers and the verdict.
	// ****************************************************************
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	// Compare and count; an unknown never matches.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One bus access, held until wait is sampled low at an edge.
	task automatic avs(input logic wr, input logic [1:0] ad, input logic [31:0] d);
		int n;
		@(posedge CLK);
		{AVS_ADDRESS, AVS_WRITEDATA, AVS_WRITE, AVS_READ} <= {ad, d, wr, !wr};
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		q = AVS_READDATA;
		{AVS_WRITE, AVS_READ} <= 2'b00;
		if (n >= 50) failures++;
	endtask
	// A plain read; the data has landed by the following edge.
	task automatic rd(input logic pb, input logic [11:0] ad);
		u_fab.op(pb, 1'b0, ad, 18'h0);
		u_fab.idle();
		@(posedge CLK);
	endtask
	// Holding reset for ten edges must clear outputs only.
	task automatic do_reset();
		RST_N <= 1'b0;
		repeat (10) @(posedge CLK);
		chk(PORT_A_RDATA | PORT_B_RDATA, 32'h0);
		chk({FULL_FLAG, EMPTY_FLAG, ALMOST_FULL_FLAG, ALMOST_EMPTY_FLAG, AVS_WAITREQUEST}, 5'h0b);
		RST_N <= 1'b1;
	endtask
	task automatic conclude();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	// Both ports write, then each reads the other's word; B then idles.
	task automatic t_dual();
		u_fab.op(1'b0, 1'b1, 12'h005, 18'h1a5);
		u_fab.op(1'b1, 1'b1, 12'h006, 18'h0c3);
		rd(1'b1, 12'h005);
		chk(PORT_B_RDATA, 18'h1a5);
		rd(1'b0, 12'h006);
		chk(PORT_A_RDATA, 18'h0c3);
		repeat (3) @(posedge CLK);
		chk(PORT_B_RDATA, 18'h1a5);
	endtask
	// Nibbles in, nine bits out, and nine bits in, nibbles out.
	task automatic t_narrow();
		avs(1'b1, 2'h0, 32'h068);
		u_fab.op(1'b0, 1'b1, 12'h002, 18'h3);
		u_fab.op(1'b0, 1'b1, 12'h003, 18'hc);
		u_fab.op(1'b1, 1'b1, 12'h004, 18'h1b6);
		rd(1'b1, 12'h001);
		chk(PORT_B_RDATA[7:0], 8'hc3);
		rd(1'b0, 12'h008);
		chk(PORT_A_RDATA, 18'h6);
		rd(1'b0, 12'h009);
		chk(PORT_A_RDATA, 18'hb);
	endtask
	// Two-port, 18 in and 9 out, with the read pipeline adding an edge.
	task automatic t_pipe();
		avs(1'b1, 2'h0, 32'h271);
		u_fab.op(1'b0, 1'b1, 12'h003, 18'h2a5b3);
		u_fab.op(1'b1, 1'b0, 12'h007, 18'h0);
		u_fab.idle();
		@(posedge CLK);
		chk(PORT_B_RDATA[7:0], 8'hc3);
		@(posedge CLK);
		chk(PORT_B_RDATA, 18'h152);
	endtask
	// Queue mode: one push, pops past empty, then fill past full.
	task automatic t_fifo();
		avs(1'b1, 2'h0, 32'h072);
		u_fab.op(1'b0, 1'b1, 12'hfff, 18'h2a5b3);
		u_fab.idle();
		@(posedge CLK);
		chk({EMPTY_FLAG, ALMOST_EMPTY_FLAG}, 2'b01);
		rd(1'b1, 12'h0aa);
		chk(PORT_B_RDATA, 18'h1b3);
		rd(1'b1, 12'h0aa);
		chk({EMPTY_FLAG, PORT_B_RDATA}, 19'h40152);
		rd(1'b1, 12'h0aa);
		chk(PORT_B_RDATA, 18'h152);
		repeat (255) u_fab.op(1'b0, 1'b1, 12'h0, 18'h0);
		u_fab.idle();
		@(posedge CLK);
		chk(FULL_FLAG, 1'b0);
		u_fab.op(1'b0, 1'b1, 12'h0, 18'h0);
		u_fab.op(1'b0, 1'b1, 12'h0, 18'h3ffff);
		u_fab.idle();
		avs(1'b0, 2'h3, 32'h0);
		chk(q, 32'h10005);
		avs(1'b1, 2'h3, 32'h0);
		avs(1'b0, 2'h3, 32'h0);
		chk(q, 32'h10005);
	endtask
	// Flush, then single bits in on A and pairs out on B, A pipelined.
	task automatic t_shapes();
		avs(1'b1, 2'h0, 32'h472);
		avs(1'b0, 2'h3, 32'h0);
		chk(q, 32'h0000000a);
		avs(1'b0, 2'h0, 32'h0);
		chk(q, 32'h072);
		avs(1'b1, 2'h0, 32'h120);
		u_fab.op(1'b0, 1'b1, 12'h010, 18'h3fffe);
		u_fab.op(1'b0, 1'b1, 12'h011, 18'h00001);
		rd(1'b1, 12'h008);
		chk(PORT_B_RDATA, 18'h2);
		rd(1'b0, 12'h011);
		chk(PORT_A_RDATA, 18'hb);
		@(posedge CLK);
		chk(PORT_A_RDATA, 18'h1);
	endtask
	// Main sequence; reset values of the control and almost-full registers come first.
	initial begin
		failures = 0;
		comparisons = 0;
		RST_N = 1'b0;
		{AVS_ADDRESS, AVS_WRITEDATA, AVS_WRITE, AVS_READ} = 36'h0;
		do_reset();
		avs(1'b0, 2'h0, 32'h0);
		chk(q, 32'h06c);
		avs(1'b0, 2'h1, 32'h0);
		chk(q, 32'he00);
		t_dual();
		do_reset();
		rd(1'b1, 12'h005);
		chk(PORT_B_RDATA, 18'h1a5);
		t_narrow();
		t_pipe();
		t_fifo();
		t_shapes();
		conclude();
	end
	// Cuts a hang short well beyond the few hundred edges the run needs.
	initial begin
		#200000;
		failures++;
		conclude();
	end
endmodule // test_erf_block
